// ===== common/rwm_pkg.sv
// Package: register map, field layout, window addresses and mode codes
package rwm_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_STC  = 8'h00;
	localparam logic [7:0] OFS_MDC  = 8'h04;
	localparam logic [7:0] OFS_SYC  = 8'h08;
	localparam logic [7:0] OFS_DIR1 = 8'h0C;
	localparam logic [7:0] OFS_DIR2 = 8'h10;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BIT_IICW  = 4;
	localparam int BIT_FLSW  = 3;
	localparam int BIT_RSVD  = 2;
	localparam int BIT_EXTERNAL_EXPANSION_ENABLE  = 7;
	localparam int BIT_STRB  = 6;
	localparam logic [7:0] RST_STC  = 8'h00;
	localparam logic [7:0] RST_DIR  = 8'h00;
	localparam logic [7:0] MSK_STC  = 8'hFB;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ****************************************
	// Mode pin codes
	// ****************************************
	localparam logic [2:0] MODE_1 = 3'h1;
	localparam logic [2:0] MODE_2 = 3'h2;
	localparam logic [2:0] MODE_3 = 3'h3;
	// ****************************************
	// Shared window addresses
	// ****************************************
	localparam logic [23:0] A_88 = 24'hFFFF88;
	localparam logic [23:0] A_89 = 24'hFFFF89;
	localparam logic [23:0] A_8E = 24'hFFFF8E;
	localparam logic [23:0] A_8F = 24'hFFFF8F;
	localparam logic [23:0] A_A0 = 24'hFFFFA0;
	localparam logic [23:0] A_A1 = 24'hFFFFA1;
	localparam logic [23:0] A_A6 = 24'hFFFFA6;
	localparam logic [23:0] A_A7 = 24'hFFFFA7;
	localparam logic [23:0] A_D8 = 24'hFFFFD8;
	localparam logic [23:0] A_D9 = 24'hFFFFD9;
	localparam logic [23:0] A_DE = 24'hFFFFDE;
	localparam logic [23:0] A_DF = 24'hFFFFDF;
	localparam logic [23:0] A_E6 = 24'hFFFEE6;
	localparam logic [23:0] A_80 = 24'hFFFF80;
	localparam logic [23:0] A_87 = 24'hFFFF87;
	localparam logic [23:0] A_FA8 = 24'hFFFEA8;
	localparam logic [23:0] A_FAE = 24'hFFFEAE;
	localparam logic [23:0] A_IO_LO = 24'hFFF000;
	localparam logic [23:0] A_IO_HI = 24'hFFF7FF;
	// Which register set answers the current CPU address
	typedef struct packed {
		logic serial_channel_one;
		logic serial_channel_two;
		logic iic_channel_one;
		logic iic_channel_zero;
		logic pulse_width_converter;
		logic display_channel_switch_reg;
		logic powerdown_ctl;
		logic flash_ctl;
		logic reserved_area;
	} rwm_win_s;
	// Port functions derived from the operating mode
	typedef struct packed {
		logic       advanced_mode;
		logic       rom_enable;
		logic       emulation_enable;
		logic       expanded;
		logic       rom_ram_limited;
		logic       port3_data_bus;
		logic       port4_bus_ctl;
		logic [7:0] port1_addr_en;
		logic [7:0] port2_addr_en;
	} rwm_mode_s;
endpackage : rwm_pkg

// ===== rtl/rwm_ctrl.sv
// Register window and operating mode control with AXI4-Lite registers
`timescale 1ns/1ps
// Notes on behaviour
// - Window select 0: serial channel 1 answers at FF88-89 and FF8E-8F.
// - Window select 1: IIC channel 1 replaces serial channel there.
// - Window select 1: pulse width converter at FFA0-A1 and FFA6-A7.
// - Window select 1: IIC channel 0 at FFD8-DF pairs, switch at FEE6.
// - Flash select 0: power-down controls at FF80-87, FEA8-FEAE reserved.
// - Flash select 1: flash controls at FEA8-FEAE, FF80-87 reserved.
// - Select bits reset to 0; STC writes mask the reserved bit to 0.
// - Two-bit timer clock select goes out to the timer.
// - Mode 1: advanced space, no ROM, ports 1-4 carry the bus.
// - Mode 1 has no on-chip emulation support.
// - 16-Mbyte modes reach external addresses only with strobe function.
// - Mode 2: advanced space, ROM on, single chip after reset.
// - Modes 2 and 3 stay single chip until expansion enable set.
// - Expanded modes 2, 3: ports 1,2 drive address only where direction bit is 1.
// - Mode 3: 64K normal space, ROM 56K and RAM 4K limits.
// - Mode pins latched into readback on first mode register read; reset releases.
// - Strobe low, in expanded modes only, in FFF000-FFF7FF when selected, else on any external.
module rwm_ctrl
	import rwm_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [23:0] cpu_addr,
	input  wire logic        ext_access,
	input  wire logic [2:0]  mode_pin,
	output rwm_win_s         win_sel,
	output logic [1:0]       timer_clock_select,
	output rwm_mode_s        mode_cfg,
	output logic             mode_valid,
	output logic             ext_addr_ok,
	output logic             shared_strobe_pin_n
);
	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] stc;
	logic       external_expansion_enable;
	logic       strobe_function_select;
	logic [7:0] dir1;
	logic [7:0] dir2;
	logic [2:0] mode_select_readback;
	logic       rb_latched;
	logic [2:0] mode_q;
	logic       wr_go;
	logic       rd_go;
	logic [31:0] next_rdata;
	logic       rd_hit;
	logic       wr_hit;
	logic       iic_window_select;
	logic       flash_window_select;

	assign iic_window_select   = stc[BIT_IICW];
	assign flash_window_select = stc[BIT_FLSW];

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	// Address and data are taken together so a write never half-lands
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign wr_hit = (s_axi_awaddr == OFS_STC) || (s_axi_awaddr == OFS_MDC) ||
		(s_axi_awaddr == OFS_SYC) || (s_axi_awaddr == OFS_DIR1) ||
		(s_axi_awaddr == OFS_DIR2);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OK : RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stc                    <= RST_STC;
			external_expansion_enable                   <= 1'b0;
			strobe_function_select <= 1'b0;
			dir1                   <= RST_DIR;
			dir2                   <= RST_DIR;
		end else if (wr_go && s_axi_wstrb[0]) begin
			case (s_axi_awaddr)
				// Reserved bit is held at its reset value
				OFS_STC:  stc <= s_axi_wdata[7:0] & MSK_STC;
				OFS_MDC:  external_expansion_enable <= s_axi_wdata[BIT_EXTERNAL_EXPANSION_ENABLE];
				OFS_SYC:  strobe_function_select <= s_axi_wdata[BIT_STRB];
				OFS_DIR1: dir1 <= s_axi_wdata[7:0];
				OFS_DIR2: dir2 <= s_axi_wdata[7:0];
				default:  stc <= stc;
			endcase
		end
	end

	always_comb begin
		next_rdata = '0;
		rd_hit     = 1'b1;
		case (s_axi_araddr)
			OFS_STC:  next_rdata[7:0] = stc;
			OFS_MDC:  begin
				next_rdata[BIT_EXTERNAL_EXPANSION_ENABLE] = external_expansion_enable;
				next_rdata[2:0] = rb_latched ? mode_select_readback : mode_pin;
			end
			OFS_SYC:  next_rdata[BIT_STRB] = strobe_function_select;
			OFS_DIR1: next_rdata[7:0] = dir1;
			OFS_DIR2: next_rdata[7:0] = dir2;
			default:  rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OK;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Mode pin readback latch and mode strap
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rb_latched           <= 1'b0;
			mode_select_readback <= '0;
		end else if (rd_go && s_axi_araddr == OFS_MDC && !rb_latched) begin
			rb_latched           <= 1'b1;
			mode_select_readback <= mode_pin;
		end
	end

	// Strap is caught on the first edge after release, never by the reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_valid <= 1'b0;
			mode_q     <= '0;
		end else if (!mode_valid) begin
			mode_valid <= 1'b1;
			mode_q     <= mode_pin;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_cfg <= '0;
		end else begin
			mode_cfg.advanced_mode <= (mode_q == MODE_1) ||
				(mode_q == MODE_2);
			mode_cfg.rom_enable <= (mode_q == MODE_2) ||
				(mode_q == MODE_3);
			mode_cfg.emulation_enable <= mode_valid &&
				(mode_q != MODE_1);
			mode_cfg.rom_ram_limited <= (mode_q == MODE_3);
			mode_cfg.expanded <= (mode_q == MODE_1) || (external_expansion_enable &&
				((mode_q == MODE_2) || (mode_q == MODE_3)));
			mode_cfg.port3_data_bus <= (mode_q == MODE_1) || external_expansion_enable;
			mode_cfg.port4_bus_ctl  <= (mode_q == MODE_1) || external_expansion_enable;
			if (mode_q == MODE_1) begin
				mode_cfg.port1_addr_en <= '1;
				mode_cfg.port2_addr_en <= '1;
			end else if (external_expansion_enable) begin
				mode_cfg.port1_addr_en <= dir1;
				mode_cfg.port2_addr_en <= dir2;
			end else begin
				mode_cfg.port1_addr_en <= '0;
				mode_cfg.port2_addr_en <= '0;
			end
		end
	end

	// Only 16 address lines leave the chip, so wide modes need the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_addr_ok <= 1'b0;
		end else begin
			ext_addr_ok <= mode_cfg.expanded && (!mode_cfg.advanced_mode ||
				strobe_function_select);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_strobe_pin_n <= 1'b1;
		end else begin
			shared_strobe_pin_n <= !(ext_access && mode_cfg.expanded &&
				(!strobe_function_select || (cpu_addr >= A_IO_LO &&
				cpu_addr <= A_IO_HI)));
		end
	end

	assign timer_clock_select = stc[1:0];

	// ****************************************
	// Shared window decode
	// ****************************************
	function automatic logic in_rng(input logic [23:0] a,
		input logic [23:0] lo, input logic [23:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_rng

	logic hit_88;
	logic hit_a0;
	logic hit_d8;
	logic hit_80;
	logic hit_ea8;
	assign hit_88  = in_rng(cpu_addr, A_88, A_89) ||
		in_rng(cpu_addr, A_8E, A_8F);
	assign hit_a0  = in_rng(cpu_addr, A_A0, A_A1) ||
		in_rng(cpu_addr, A_A6, A_A7);
	assign hit_d8  = in_rng(cpu_addr, A_D8, A_D9) ||
		in_rng(cpu_addr, A_DE, A_DF);
	assign hit_80  = in_rng(cpu_addr, A_80, A_87);
	assign hit_ea8 = in_rng(cpu_addr, A_FA8, A_FAE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			win_sel <= '0;
		end else begin
			win_sel.serial_channel_one <= hit_88 && !iic_window_select;
			win_sel.iic_channel_one    <= hit_88 && iic_window_select;
			win_sel.serial_channel_two <= (hit_a0 || hit_d8) &&
				!iic_window_select;
			win_sel.pulse_width_converter <= hit_a0 && iic_window_select;
			win_sel.iic_channel_zero   <= hit_d8 && iic_window_select;
			win_sel.display_channel_switch_reg <= (cpu_addr == A_E6) &&
				iic_window_select;
			win_sel.powerdown_ctl <= hit_80 && !flash_window_select;
			win_sel.flash_ctl     <= hit_ea8 && flash_window_select;
			win_sel.reserved_area <= flash_window_select ? hit_80 :
				hit_ea8;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_iic_one_map: assert property (
		hit_88 && iic_window_select |=> win_sel.iic_channel_one &&
		!win_sel.serial_channel_one)
		else $error("IIC channel 1 not mapped");
	a_serial_one_map: assert property (
		hit_88 && !iic_window_select |=> win_sel.serial_channel_one &&
		!win_sel.iic_channel_one)
		else $error("serial channel 1 not mapped");
	a_pwm_map: assert property (
		win_sel.pulse_width_converter |-> $past(iic_window_select))
		else $error("converter selected without window bit");
	a_flash_excl: assert property (
		!(win_sel.flash_ctl && win_sel.powerdown_ctl))
		else $error("flash and power-down both selected");
	a_flash_map: assert property (
		hit_80 && flash_window_select |=> win_sel.reserved_area &&
		!win_sel.powerdown_ctl)
		else $error("power-down area not reserved");
	a_rsvd_zero: assert property (
		!stc[BIT_RSVD])
		else $error("reserved bit set");
	a_timer_sel: assert property (
		wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_STC |=>
		timer_clock_select == $past(s_axi_wdata[1:0]))
		else $error("timer clock select not delivered");
	sequence s_rd_mdc;
		rd_go && s_axi_araddr == OFS_MDC && !rb_latched;
	endsequence
	a_latch_hold: assert property (
		s_rd_mdc ##1 (rb_latched && !s_rd_mdc)[*2] |->
		$stable(mode_select_readback))
		else $error("mode readback not held");
	a_mode1_emu: assert property (
		mode_valid && mode_q == MODE_1 |=> !mode_cfg.emulation_enable)
		else $error("emulation in mode 1");
	a_single_chip: assert property (
		mode_valid && !external_expansion_enable && mode_q != MODE_1 |=> !mode_cfg.expanded)
		else $error("expanded without enable");
endmodule : rwm_ctrl

// ===== tb/rwm_cpu_model.sv
// CPU side model: presents peripheral addresses and external cycles
`timescale 1ns/1ps
module rwm_cpu_model (
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic [23:0] go_addr,
	input  wire logic        go_ext,
	output logic [23:0]      cpu_addr,
	output logic             ext_access
);
	initial begin
		cpu_addr   = 24'h000000;
		ext_access = 1'b0;
	end
	// Outside a cycle the address floats: show the inverse, not a held value
	always @(posedge ref_clk) begin
		cpu_addr   <= go ? go_addr : ~cpu_addr;
		ext_access <= go & go_ext;
	end
endmodule : rwm_cpu_model

// ===== tb/register_window_and_mode_control_tb.sv
// Self-checking bench for window decode, mode and register control
`timescale 1ns/1ps
module register_window_and_mode_control_tb
	import rwm_pkg::*;
;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0]  r;
	} rwm_note_s;
	logic        ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, go, go_ext, iic, fls, strb;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, mode_valid, ext_addr_ok, shared_strobe_pin_n;
	logic        ext_access, xp;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  mode_pin;
	logic [1:0]  s_axi_bresp, s_axi_rresp, timer_clock_select;
	logic [23:0] cpu_addr, go_addr;
	logic [23:0] tbl [16];
	rwm_win_s    win_sel;
	rwm_mode_s   mode_cfg;
	rwm_note_s   wq[$], rq[$], nb;
	int          fail_count, samples_checked, cyc, k, j;
	int          seed = 34037;

	rwm_ctrl i_rwm_ctrl (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_addr, .ext_access,
		.mode_pin, .win_sel, .timer_clock_select, .mode_cfg, .mode_valid,
		.ext_addr_ok, .shared_strobe_pin_n);
	rwm_cpu_model i_rwm_cpu_model (.ref_clk, .go, .go_addr, .go_ext,
		.cpu_addr, .ext_access);

	always #2 ref_clk = ~ref_clk;

	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// Sized well past the longest run so only a real hang trips it
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	always @(posedge ref_clk) begin
		if (s_axi_bvalid && s_axi_bready && wq.size() > 0) begin
			nb = wq.pop_front();
			check("bresp", s_axi_bresp, nb.r);
		end
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
			nb = rq.pop_front();
			check("rdata", s_axi_rdata & nb.m, nb.d);
			check("rresp", s_axi_rresp, nb.r);
		end
	end

	// ********
	// Bus tasks
	// ********
	task axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] r);
		wq.push_back('{d: 32'h0, m: 32'h0, r: r});
		rnd = $random(seed);
		@(posedge ref_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {rnd[31:8], d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] r);
		rq.push_back('{d: d, m: m, r: r});
		@(posedge ref_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task rst(input logic [2:0] m);
		@(posedge ref_clk);
		mode_pin <= m;
		rst_n    <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask : rst

	task cfg(input logic a, r, x, l, input logic [7:0] p1, p2);
		repeat (2) @(posedge ref_clk);
		#1;
		check("mode_cfg", {mode_cfg.advanced_mode, mode_cfg.rom_enable,
			mode_cfg.expanded, mode_cfg.rom_ram_limited,
			mode_cfg.port3_data_bus, mode_cfg.port4_bus_ctl,
			mode_cfg.port1_addr_en, mode_cfg.port2_addr_en},
			{a, r, x, l, x, x, p1, p2});
	endtask : cfg

	function automatic rwm_win_s ew(input logic [23:0] a);
		logic s1, s2, d0, pd, fc;
		s1 = a inside {A_88, A_89, A_8E, A_8F};
		s2 = a inside {A_A0, A_A1, A_A6, A_A7};
		d0 = a inside {A_D8, A_D9, A_DE, A_DF};
		pd = a >= A_80 && a <= A_87;
		fc = a >= A_FA8 && a <= A_FAE;
		return '{!iic && s1, !iic && (s2 || d0), iic && s1, iic && d0,
			iic && s2, iic && a == A_E6, !fls && pd, fls && fc,
			(fls && pd) || (!fls && fc)};
	endfunction : ew

	task win(input logic [23:0] a, input logic e);
		@(posedge ref_clk);
		go_addr <= a;
		go_ext  <= e;
		go      <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("win_sel", win_sel, ew(a));
		// Strobe pin only acts once the bus has been opened to the outside
		check("strobe", shared_strobe_pin_n,
			!(xp && e && (!strb || (a >= A_IO_LO && a <= A_IO_HI))));
	endtask : win

	// ********
	// Scenarios
	// ********
	initial begin
		{ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, go, go_ext, iic, fls, strb} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{mode_pin, go_addr, cyc, xp} = '0;
		tbl = '{A_88, A_89, A_8E, A_8F, 24'hFFFF8A, A_A0, A_A7, A_D8,
			A_DF, 24'hFFFFDA, A_E6, A_80, A_87, A_FA8, A_FAE, 24'hFFFEAF};
		rst(MODE_2);
		check("mode_valid", mode_valid, 1'b1);
		cfg(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
		axi_rd(OFS_STC, 32'h0, 32'hFFFFFFFF, RESP_OK);
		axi_rd(OFS_MDC, {29'h0, MODE_2}, 32'hFFFFFF87, RESP_OK);
		@(posedge ref_clk) mode_pin <= MODE_3;
		axi_rd(OFS_MDC, {29'h0, MODE_2}, 32'hFFFFFF87, RESP_OK);
		axi_rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_ERR);
		axi_wr(8'h14, 8'hAA, 4'hF, RESP_ERR);
		axi_wr(OFS_STC, 8'hFF, 4'hE, RESP_OK);
		axi_rd(OFS_STC, 32'h0, 32'hFFFFFFFF, RESP_OK);
		axi_wr(OFS_STC, 8'hFF, 4'hF, RESP_OK);
		axi_rd(OFS_STC, 32'hFB, 32'hFFFFFFFF, RESP_OK);
		for (k = 0; k < 4; k++) begin
			{iic, fls} = k[1:0];
			axi_wr(OFS_STC, {3'h0, iic, fls, 1'b0, k[1:0]}, 4'hF, RESP_OK);
			check("timer_clock_select", timer_clock_select, k[1:0]);
			for (j = 0; j < 16; j++)
				win(tbl[j], 1'b0);
			rnd = $random(seed);
			win({16'hFFFF, rnd[7:0]}, rnd[8]);
		end
		axi_wr(OFS_MDC, 8'h80, 4'hF, RESP_OK);
		xp = 1'b1;
		cfg(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
		check("ext_addr_ok", ext_addr_ok, 1'b0);
		axi_wr(OFS_DIR1, 8'h5A, 4'hF, RESP_OK);
		axi_wr(OFS_DIR2, 8'hC3, 4'hF, RESP_OK);
		cfg(1'b1, 1'b1, 1'b1, 1'b0, 8'h5A, 8'hC3);
		for (k = 0; k < 2; k++) begin
			strb = k[0];
			axi_wr(OFS_SYC, {1'b0, strb, 6'h0}, 4'hF, RESP_OK);
			// Odd entries are moved into the strobe range to see it go low
			for (j = 0; j < 16; j++)
				win(tbl[j] ^ {12'h000, j[0], 11'h000}, 1'b1);
		end
		check("ext_addr_ok", ext_addr_ok, 1'b1);
		strb = 1'b0;
		rst(MODE_3);
		cfg(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
		axi_rd(OFS_MDC, {29'h0, MODE_3}, 32'hFFFFFF87, RESP_OK);
		axi_wr(OFS_MDC, 8'h80, 4'hF, RESP_OK);
		cfg(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00);
		check("ext_addr_ok", ext_addr_ok, 1'b1);
		rst(MODE_1);
		cfg(1'b1, 1'b0, 1'b1, 1'b0, 8'hFF, 8'hFF);
		check("emulation", mode_cfg.emulation_enable, 1'b0);
		check("ext_addr_ok", ext_addr_ok, 1'b0);
		rst(3'h0);
		cfg(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		close_out();
	end
endmodule : register_window_and_mode_control_tb
